// *** core/oad_decoder.sv ***
// Operand addressing decoder: gathers instruction bytes, resolves operands,
// counts execution cycles and hosts the data pointer registers.
// Assumes program memory offers one byte per cycle under valid and ready,
// and that datapath logic on mclk supplies R0, R1, bank select and branch condition.
//
// Operation
// RULE_01: Register decrement-branch is 2 bytes, 2 cycles, 3 when branching.
// RULE_02: Direct decrement-branch is 3 bytes, 3 cycles, 4 when branching.
// RULE_03: Indirect compare-branch is 3 bytes, 4 cycles, 5 when branching.
// RULE_04: No-operation is 1 byte, 1 cycle; opcode a5 behaves identically.
// RULE_05: Register operand picks R0 to R7 in the selected bank.
// RULE_06: Indirect operand uses R0 or R1 contents as RAM address.
// RULE_07: Relative offset is signed 8 bits from the next instruction.
// RULE_08: Direct below 80 hits RAM, 80 and above hits special registers.
// RULE_09: Bit operand names one bit in RAM or a special register.
// RULE_10: Page target replaces low 11 bits within the 2 kB page.
// RULE_11: Long target is a full 16-bit address.
// RULE_12: Pointer low byte at 82 is read-write and resets to zero.
// RULE_13: Pointer high byte at 83 is read-write and resets to zero.
// RULE_14: Software should write reserved bits with their documented values.
// RULE_15: Bank codes 00 to 11 place registers at 00, 08, 10, 18.
// RULE_16: Relative target sign-extends and wraps modulo 16 bits.
`timescale 1ns/1ps
`include "oad_map.svh"

module oad_decoder (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	// Program memory byte stream
	input  wire logic [7:0]            prog_byte,
	input  wire logic                  prog_valid,
	output logic                       prog_ready,
	input  wire logic [15:0]           instr_addr,
	// Datapath context
	input  wire logic [1:0]            bank_select_field,
	input  wire logic [7:0]            reg_r0,
	input  wire logic [7:0]            reg_r1,
	input  wire logic                  branch_cond,
	// Decode results
	output logic                       instr_done,
	output logic [7:0]                 instr_opcode,
	output logic [1:0]                 instr_len,
	output logic [2:0]                 instr_cycles,
	output logic                       instr_unknown,
	output oad_pkg::oad_operand_s      operand,
	// Special register bus
	input  wire oad_pkg::oad_sfr_req_s sfr_req,
	output logic [7:0]                 sfr_rdata,
	output logic                       sfr_hit,
	output logic [15:0]                data_pointer_word
);

	// ******************************
	// Decode helpers
	// ******************************
	function automatic oad_pkg::oad_info_s decode_op(input logic [7:0] op);
		oad_pkg::oad_info_s i;
		i = '{kind: oad_pkg::OAD_K_NONE, len: `OAD_LEN_1, cyc_nb: `OAD_CYC_1,
			cyc_br: `OAD_CYC_1};
		// RULE_04: both no-operation codes
		if (op == `OAD_OP_NOP || op == `OAD_OP_NOP_ALT)
			i.kind = oad_pkg::OAD_K_NOP;
		// RULE_01: register decrement
		else if (op[7:3] == `OAD_OP_DEC_REG)
			i = '{oad_pkg::OAD_K_DEC_REG, `OAD_LEN_2, `OAD_CYC_2, `OAD_CYC_3};
		// RULE_02: direct decrement
		else if (op == `OAD_OP_DEC_DIR)
			i = '{oad_pkg::OAD_K_DEC_DIR, `OAD_LEN_3, `OAD_CYC_3, `OAD_CYC_4};
		// RULE_03: indirect compare
		else if (op[7:1] == `OAD_OP_CMP_IND)
			i = '{oad_pkg::OAD_K_CMP_IND, `OAD_LEN_3, `OAD_CYC_4, `OAD_CYC_5};
		else if (op == `OAD_OP_SHORT_JUMP)
			i = '{oad_pkg::OAD_K_SHORT, `OAD_LEN_2, `OAD_CYC_3, `OAD_CYC_3};
		else if (op == `OAD_OP_JB)
			i = '{oad_pkg::OAD_K_JB, `OAD_LEN_3, `OAD_CYC_3, `OAD_CYC_4};
		else if (op[4:0] == `OAD_OP_ABS_JUMP_LO || op[4:0] == `OAD_OP_ABS_CALL_LO)
			i = '{oad_pkg::OAD_K_ABS, `OAD_LEN_2, `OAD_CYC_3, `OAD_CYC_3};
		else if (op == `OAD_OP_LONG_JUMP || op == `OAD_OP_LONG_CALL)
			i = '{oad_pkg::OAD_K_LONG, `OAD_LEN_3, `OAD_CYC_4, `OAD_CYC_4};
		return i;
	endfunction

	// RULE_05: bank base plus register index
	// RULE_15: bank code times eight
	function automatic logic [7:0] work_reg_addr(input logic [1:0] bank,
		input logic [2:0] idx);
		return {3'h0, bank, idx};
	endfunction

	// RULE_16: sign extend, wrap at 16 bits
	function automatic logic [15:0] rel_target(input logic [15:0] next_pc,
		input logic [7:0] rel);
		return 16'(next_pc + {{8{rel[7]}}, rel});
	endfunction

	// ******************************
	// State
	// ******************************
	typedef struct packed {
		oad_pkg::oad_state_e st;
		oad_pkg::oad_info_s  info;
		logic [7:0]          op;
		logic [7:0]          b1;
		logic [1:0]          got;
		logic [2:0]          cnt;
		logic                taken;
		logic                ready;
		logic                done;
		logic [2:0]          cycles;
		logic                unknown;
		oad_pkg::oad_operand_s opd;
	} oad_dec_s;

	oad_dec_s s_q;
	oad_dec_s s_d;

	oad_pkg::oad_info_s inf_now;
	logic [7:0]         op_now;
	logic [15:0]        next_pc;
	logic [7:0]         last_b;
	logic [7:0]         bit_b;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		op_now   = (s_q.st == oad_pkg::OAD_IDLE) ? prog_byte : s_q.op;
		inf_now  = (s_q.st == oad_pkg::OAD_IDLE) ? decode_op(prog_byte) : s_q.info;
		next_pc  = 16'(instr_addr + {14'h0, inf_now.len});
		last_b   = prog_byte;
		bit_b    = (s_q.st == oad_pkg::OAD_IDLE) ? 8'h00 : s_q.b1;
		unique case (s_q.st)
			oad_pkg::OAD_IDLE: begin
				if (prog_valid) begin
					s_d.op      = prog_byte;
					s_d.info    = inf_now;
					s_d.got     = 2'h1;
					s_d.cnt     = 3'h1;
					s_d.unknown = (inf_now.kind == oad_pkg::OAD_K_NONE);
					s_d.opd     = '0;
					s_d.st      = (inf_now.len == `OAD_LEN_1) ? oad_pkg::OAD_EXEC
						: oad_pkg::OAD_FETCH;
					s_d.taken   = 1'b0;
				end
			end
			oad_pkg::OAD_FETCH: begin
				s_d.cnt = 3'(s_q.cnt + 3'h1);
				if (prog_valid) begin
					s_d.got = 2'(s_q.got + 2'h1);
					if (s_q.got == 2'h1)
						s_d.b1 = prog_byte;
					if (2'(s_q.got + 2'h1) == s_q.info.len) begin
						s_d.st    = oad_pkg::OAD_EXEC;
						s_d.taken = branch_cond;
						unique case (s_q.info.kind)
							oad_pkg::OAD_K_DEC_REG: begin
								s_d.opd.ram_addr  = work_reg_addr(bank_select_field,
									op_now[2:0]);
								s_d.opd.ram_valid = 1'b1;
							end
							oad_pkg::OAD_K_DEC_DIR: begin
								// RULE_08: high bit selects special registers
								s_d.opd.direct_addr   = s_q.b1;
								s_d.opd.direct_is_sfr = s_q.b1[`OAD_SFR_BIT];
								s_d.opd.direct_valid  = 1'b1;
							end
							oad_pkg::OAD_K_CMP_IND: begin
								// RULE_06: R0 or R1 by opcode bit
								s_d.opd.ram_addr  = op_now[0] ? reg_r1 : reg_r0;
								s_d.opd.ram_valid = 1'b1;
							end
							oad_pkg::OAD_K_JB: begin
								// RULE_09: bit area byte or special register byte
								s_d.opd.bit_byte  = bit_b[`OAD_SFR_BIT] ? {bit_b[7:3], 3'h0}
									: {`OAD_BIT_AREA, bit_b[6:3]};
								s_d.opd.bit_index = bit_b[2:0];
								s_d.opd.bit_valid = 1'b1;
							end
							default: begin
							end
						endcase
						// RULE_07: offset from next instruction
						if (s_q.info.kind inside {oad_pkg::OAD_K_DEC_REG,
							oad_pkg::OAD_K_DEC_DIR, oad_pkg::OAD_K_CMP_IND,
							oad_pkg::OAD_K_SHORT, oad_pkg::OAD_K_JB})
							s_d.opd.target = rel_target(next_pc, last_b);
						// RULE_10: keep page bits of next address
						if (s_q.info.kind == oad_pkg::OAD_K_ABS)
							s_d.opd.target = {next_pc[`OAD_PAGE_MSB:`OAD_PAGE_LSB],
								op_now[7:5], prog_byte};
						// RULE_11: full address from two bytes
						if (s_q.info.kind == oad_pkg::OAD_K_LONG)
							s_d.opd.target = {s_q.b1, prog_byte};
						s_d.opd.target_valid = s_q.info.kind != oad_pkg::OAD_K_NONE;
					end
				end
			end
			oad_pkg::OAD_EXEC: begin
				// RULE_01: branch adds one cycle
				s_d.cycles = s_q.taken ? s_q.info.cyc_br : s_q.info.cyc_nb;
				if (s_q.cnt >= s_d.cycles) begin
					s_d.done = 1'b1;
					s_d.st   = oad_pkg::OAD_IDLE;
				end else begin
					s_d.cnt = 3'(s_q.cnt + 3'h1);
				end
			end
		endcase
		// Ready is registered, so it looks at the next state
		s_d.ready = (s_d.st != oad_pkg::OAD_EXEC);
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_q       <= '0;
			s_q.st    <= oad_pkg::OAD_IDLE;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ******************************
	// Data pointer registers
	// ******************************
	oad_pointer u_pointer (
		.mclk              (mclk),
		.rstn              (rstn),
		.sfr_req           (sfr_req),
		.sfr_rdata         (sfr_rdata),
		.sfr_hit           (sfr_hit),
		.data_pointer_word (data_pointer_word)
	);

	assign prog_ready    = s_q.ready;
	assign instr_done    = s_q.done;
	assign instr_opcode  = s_q.op;
	assign instr_len     = s_q.info.len;
	assign instr_cycles  = s_q.cycles;
	assign instr_unknown = s_q.unknown;
	assign operand       = s_q.opd;

endmodule // oad_decoder

// *** core/oad_map.svh ***
// Constants for the operand addressing decoder and data pointer.
// Assumes inclusion by bare name from the core files.
`ifndef OAD_MAP_SVH
`define OAD_MAP_SVH

// Opcodes
`define OAD_OP_NOP       8'h00
`define OAD_OP_NOP_ALT   8'ha5
`define OAD_OP_DEC_DIR      8'hd5
`define OAD_OP_DEC_REG      5'h1b
`define OAD_OP_CMP_IND      7'h5b
`define OAD_OP_SHORT_JUMP   8'h80
`define OAD_OP_JB           8'h20
`define OAD_OP_LONG_JUMP    8'h02
`define OAD_OP_LONG_CALL    8'h12
`define OAD_OP_ABS_JUMP_LO  5'h01
`define OAD_OP_ABS_CALL_LO  5'h11

// Lengths in bytes and cycle counts (not taken / taken)
`define OAD_LEN_1        2'h1
`define OAD_LEN_2        2'h2
`define OAD_LEN_3        2'h3
`define OAD_CYC_1        3'h1
`define OAD_CYC_2        3'h2
`define OAD_CYC_3        3'h3
`define OAD_CYC_4        3'h4
`define OAD_CYC_5        3'h5

// Operand address spaces
`define OAD_SFR_BIT      7
`define OAD_BIT_AREA     4'h2
`define OAD_PAGE_MSB     15
`define OAD_PAGE_LSB     11

// Data pointer special function registers
`define OAD_PTR_LOW_ADDR  8'h82
`define OAD_PTR_HIGH_ADDR 8'h83
`define OAD_DP_RESET     8'h00

`endif

// *** core/oad_pkg.sv ***
// Types shared by the operand addressing decoder files.
// Assumes oad_map.svh provides the constants.
package oad_pkg;

	typedef enum logic [2:0] {
		OAD_IDLE  = 3'b001,
		OAD_FETCH = 3'b010,
		OAD_EXEC  = 3'b100
	} oad_state_e;

	typedef enum logic [3:0] {
		OAD_K_NONE, OAD_K_NOP, OAD_K_DEC_REG, OAD_K_DEC_DIR, OAD_K_CMP_IND,
		OAD_K_SHORT, OAD_K_JB, OAD_K_ABS, OAD_K_LONG
	} oad_kind_e;

	typedef struct packed {
		oad_kind_e  kind;
		logic [1:0] len;
		logic [2:0] cyc_nb;
		logic [2:0] cyc_br;
	} oad_info_s;

	typedef struct packed {
		logic [7:0]  ram_addr;
		logic        ram_valid;
		logic [7:0]  direct_addr;
		logic        direct_is_sfr;
		logic        direct_valid;
		logic [7:0]  bit_byte;
		logic [2:0]  bit_index;
		logic        bit_valid;
		logic [15:0] target;
		logic        target_valid;
	} oad_operand_s;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} oad_sfr_req_s;

endpackage

// *** core/oad_pointer.sv ***
// Sixteen-bit data pointer held as two special function registers.
// Assumes a one-cycle registered read answer on the special register bus.
`timescale 1ns/1ps
`include "oad_map.svh"

module oad_pointer (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	// Special register bus
	input  wire oad_pkg::oad_sfr_req_s sfr_req,
	output logic [7:0]                sfr_rdata,
	output logic                      sfr_hit,
	// Pointer word
	output logic [15:0]               data_pointer_word
);

	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic [7:0] rdata;
		logic       hit;
	} oad_dp_s;

	oad_dp_s dp_q;
	oad_dp_s dp_d;

	always_comb begin
		dp_d       = dp_q;
		dp_d.rdata = 8'h00;
		dp_d.hit   = 1'b0;
		// RULE_12: low byte access
		if (sfr_req.addr == `OAD_PTR_LOW_ADDR) begin
			dp_d.hit   = sfr_req.rd | sfr_req.wr;
			dp_d.rdata = sfr_req.rd ? dp_q.low : 8'h00;
			if (sfr_req.wr)
				dp_d.low = sfr_req.wdata;
		end
		// RULE_13: high byte access
		if (sfr_req.addr == `OAD_PTR_HIGH_ADDR) begin
			dp_d.hit   = sfr_req.rd | sfr_req.wr;
			dp_d.rdata = sfr_req.rd ? dp_q.high : 8'h00;
			if (sfr_req.wr)
				dp_d.high = sfr_req.wdata;
		end
	end

	// RULE_12: zero after reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dp_q <= '{low: `OAD_DP_RESET, high: `OAD_DP_RESET, rdata: 8'h00, hit: 1'b0};
		end else begin
			dp_q <= dp_d;
		end
	end

	assign sfr_rdata         = dp_q.rdata;
	assign sfr_hit           = dp_q.hit;
	assign data_pointer_word = {dp_q.high, dp_q.low};

endmodule // oad_pointer

// *** test/oad_decoder_checker.sv ***
// Port checks for the operand addressing decoder.
// Assumes a bind onto oad_decoder and one clock, mclk.
`timescale 1ns/1ps
module oad_decoder_checker (
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  rstn,
	// Program stream
	input wire logic [7:0]            prog_byte,
	input wire logic                  prog_valid,
	input wire logic                  prog_ready,
	input wire logic [15:0]           instr_addr,
	// Decode results
	input wire logic                  instr_done,
	input wire logic [7:0]            instr_opcode,
	input wire logic [1:0]            instr_len,
	input wire logic [2:0]            instr_cycles,
	input wire oad_pkg::oad_operand_s operand,
	// Special register bus
	input wire oad_pkg::oad_sfr_req_s sfr_req,
	input wire logic [7:0]            sfr_rdata,
	input wire logic                  sfr_hit,
	input wire logic [15:0]           data_pointer_word
);
	// Byte taken while done is high counts as an opcode too
	logic        opc_q;
	logic [3:0]  n_q;
	logic        first;
	logic [15:0] nxt;
	logic [15:0] addr_q;
	assign first = prog_valid && prog_ready && (opc_q || instr_done);
	// Address kept from the take; it may already move while done is high
	assign nxt   = addr_q + 16'h2;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			opc_q  <= 1'b1;
			n_q    <= 4'h0;
			addr_q <= 16'h0000;
		end else begin
			opc_q  <= first ? 1'b0 : (opc_q || instr_done);
			n_q    <= first ? 4'h1 : n_q + 4'h1;
			addr_q <= first ? instr_addr : addr_q;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence exec_then_done;
		!prog_ready ##1 (instr_done && prog_ready);
	endsequence
	chk_nop_timing: assert property (
		first && (prog_byte == 8'h00 || prog_byte == 8'ha5) |=> exec_then_done)
		else $error("no-operation timing wrong");
	chk_cycle_count: assert property (
		instr_done |-> n_q == {1'b0, instr_cycles} + 4'h1)
		else $error("done not after counted cycles");
	chk_dec_reg: assert property (
		instr_done && instr_opcode[7:3] == 5'h1b |-> instr_len == 2'h2
		&& instr_cycles inside {3'h2, 3'h3}) else $error("register decrement shape wrong");
	chk_dec_direct: assert property (
		instr_done && instr_opcode == 8'hd5 |-> instr_len == 2'h3
		&& instr_cycles inside {3'h3, 3'h4}) else $error("direct decrement shape wrong");
	chk_cmp_indirect: assert property (
		instr_done && instr_opcode[7:1] == 7'h5b |-> instr_len == 2'h3
		&& instr_cycles inside {3'h4, 3'h5}) else $error("indirect compare shape wrong");
	chk_bank_window: assert property (
		instr_done && instr_opcode[7:3] == 5'h1b |-> operand.ram_addr[7:5] == 3'h0
		&& operand.ram_addr[2:0] == instr_opcode[2:0]) else $error("register address wrong");
	chk_direct_space: assert property (
		instr_done && operand.direct_valid |-> operand.direct_is_sfr == operand.direct_addr[7])
		else $error("direct space wrong");
	chk_page_target: assert property (
		instr_done && instr_opcode[3:0] == 4'h1 |-> operand.target[15:11] == nxt[15:11]
		&& operand.target[10:8] == instr_opcode[7:5]) else $error("page target wrong");
	chk_ptr_low: assert property (
		sfr_req.wr && sfr_req.addr == 8'h82 |=> sfr_hit
		&& data_pointer_word[7:0] == $past(sfr_req.wdata)) else $error("low byte write lost");
	chk_ptr_high: assert property (
		sfr_req.wr && sfr_req.addr == 8'h83 |=> sfr_hit
		&& data_pointer_word[15:8] == $past(sfr_req.wdata)) else $error("high byte write lost");
	chk_sfr_miss: assert property (
		(sfr_req.rd || sfr_req.wr) && sfr_req.addr[7:1] != 7'h41 |=> !sfr_hit
		&& sfr_rdata == 8'h00) else $error("foreign address answered");
endmodule // oad_decoder_checker

bind oad_decoder oad_decoder_checker u_chk (
	.mclk, .rstn, .prog_byte, .prog_valid, .prog_ready, .instr_addr, .instr_done,
	.instr_opcode, .instr_len, .instr_cycles, .operand, .sfr_req, .sfr_rdata, .sfr_hit,
	.data_pointer_word
);

// *** test/oad_prog_mem.sv ***
// Program memory model offering up to three instruction bytes.
// Assumes go is pulsed only while busy is low.
`timescale 1ns/1ps
module oad_prog_mem (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// Bench control
	input  wire logic        go,
	input  wire logic        slow,
	input  wire logic [1:0]  cnt,
	input  wire logic [23:0] bytes,
	output logic             busy,
	// Byte stream
	input  wire logic        prog_ready,
	output logic [7:0]       prog_byte,
	output logic             prog_valid
);
	logic [23:0] sh_q;
	logic [1:0]  left_q;
	logic        wait_q;
	assign busy = (left_q != 2'h0);
	// Idle byte is inverted so a stale value never passes for data
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sh_q       <= 24'h0;
			left_q     <= 2'h0;
			wait_q     <= 1'b0;
			prog_valid <= 1'b0;
			prog_byte  <= 8'h00;
		end else if (go && !busy) begin
			sh_q       <= bytes;
			left_q     <= cnt;
			wait_q     <= slow;
			prog_valid <= !slow;
			prog_byte  <= slow ? ~prog_byte : bytes[23:16];
		end else if (wait_q) begin
			wait_q     <= 1'b0;
			prog_valid <= 1'b1;
			prog_byte  <= sh_q[23:16];
		end else if (prog_valid && prog_ready) begin
			sh_q       <= sh_q << 8;
			left_q     <= left_q - 2'h1;
			prog_valid <= (left_q != 2'h1);
			prog_byte  <= (left_q == 2'h1) ? ~prog_byte : sh_q[15:8];
		end
	end
endmodule // oad_prog_mem

// *** test/operand_addressing_and_data_pointer_bench.sv ***
// Self-checking bench for the operand addressing decoder.
// Assumes oad_prog_mem feeds the byte stream.
`timescale 1ns/1ps
module operand_addressing_and_data_pointer_bench;
	typedef struct packed {
		logic [15:0] addr;
		logic [23:0] bytes;
		logic [1:0]  cnt;
		logic        cond;
		logic [2:0]  cyc;
		logic [15:0] tgt;
		logic [7:0]  ram;
	} oad_row_s;
	logic                  mclk, rstn, go, slow, busy, prog_valid, prog_ready;
	logic                  branch_cond, instr_done, sfr_hit, instr_unknown, hit_v;
	logic [1:0]            cnt, instr_len, bank_select_field;
	logic [2:0]            instr_cycles;
	logic [7:0]            prog_byte, reg_r0, reg_r1, sfr_rdata, instr_opcode, rd_v;
	logic [15:0]           instr_addr, data_pointer_word;
	logic [23:0]           bytes;
	oad_pkg::oad_operand_s operand;
	oad_pkg::oad_sfr_req_s sfr_req;
	int                    errors, checks, cyc_cnt;
	oad_row_s              r;
	oad_row_s rows [15] = '{
		'{16'h0100,24'h000000,2'h1,1'h0,3'h1,16'h0000,8'h00},
		'{16'h0100,24'ha50000,2'h1,1'h1,3'h1,16'h0000,8'h00},
		'{16'h0100,24'hdb1000,2'h2,1'h0,3'h2,16'h0112,8'h0b},
		'{16'h0100,24'hdffe00,2'h2,1'h1,3'h3,16'h0100,8'h0f},
		'{16'h0100,24'hd585f0,2'h3,1'h0,3'h3,16'h00f3,8'h00},
		'{16'h0100,24'hd53005,2'h3,1'h1,3'h4,16'h0108,8'h00},
		'{16'h0100,24'hb75580,2'h3,1'h0,3'h4,16'h0083,8'h41},
		'{16'h0100,24'hb6aa7f,2'h3,1'h1,3'h5,16'h0182,8'h20},
		'{16'h0000,24'h80fd00,2'h2,1'h0,3'h3,16'hffff,8'h00},
		'{16'h07fe,24'he12300,2'h2,1'h0,3'h3,16'h0f23,8'h00},
		'{16'h0100,24'h510000,2'h2,1'h0,3'h3,16'h0200,8'h00},
		'{16'h0100,24'h02abcd,2'h3,1'h0,3'h4,16'habcd,8'h00},
		'{16'h0100,24'h121f00,2'h3,1'h0,3'h4,16'h1f00,8'h00},
		'{16'h0100,24'h202b04,2'h3,1'h1,3'h4,16'h0107,8'h00},
		'{16'h0100,24'h208b00,2'h3,1'h0,3'h3,16'h0103,8'h00}};

	oad_decoder dut (
		.mclk, .rstn, .prog_byte, .prog_valid, .prog_ready, .instr_addr, .bank_select_field,
		.reg_r0, .reg_r1, .branch_cond, .instr_done, .instr_opcode, .instr_len,
		.instr_cycles, .instr_unknown, .operand, .sfr_req, .sfr_rdata, .sfr_hit,
		.data_pointer_word);
	oad_prog_mem u_mem (.mclk, .rstn, .go, .slow, .cnt, .bytes, .busy, .prog_ready,
		.prog_byte, .prog_valid);

	// ****************
	// Shared tasks
	// ****************
	task automatic stop_test();
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic do_reset();
		rstn = 1'b0;
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
	endtask
	task automatic run(input oad_row_s x, input logic s);
		int k;
		instr_addr = x.addr;
		branch_cond = x.cond;
		bytes = x.bytes;
		cnt = x.cnt;
		slow = s;
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		k = 0;
		while (instr_done !== 1'b1 && k < 20) begin
			@(negedge mclk);
			k++;
		end
		chk("done", instr_done, 1'b1);
	endtask
	// whole bytes written
	// Answer taken while it stands, then one idle cycle between requests
	task automatic special_function_register(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_req = '{a, w, !w, d};
		@(negedge mclk);
		rd_v = sfr_rdata;
		hit_v = sfr_hit;
		sfr_req = '0;
		@(negedge mclk);
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Run takes under two hundred cycles; far above that means a hang
	always @(posedge mclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 5000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		{go, slow, cnt, bytes, instr_addr, branch_cond, errors, checks, cyc_cnt} = '0;
		bank_select_field = 2'h1;
		reg_r0 = 8'h20;
		reg_r1 = 8'h41;
		sfr_req = '0;
		do_reset();
		chk("ready", prog_ready, 1'b1);
		chk("dp reset", data_pointer_word, 16'h0000);
		for (int i = 0; i < 15; i++) begin
			r = rows[i];
			run(r, i[0]);
			chk("len", instr_len, r.cnt);
			chk("cycles", instr_cycles, r.cyc);
			chk("target", operand.target, r.tgt);
			chk("opcode", instr_opcode, r.bytes[23:16]);
			chk("unknown", instr_unknown, 1'b0);
			chk("valid", {operand.target_valid, operand.ram_valid, operand.direct_valid,
				operand.bit_valid}, {r.cnt != 2'h1, r.ram != 8'h00,
				r.bytes[23:16] == 8'hd5, r.bytes[23:16] == 8'h20});
			if (r.bytes[23:16] == 8'hd5) chk("direct", operand.direct_addr, r.bytes[15:8]);
			if (r.ram != 8'h00) chk("ram", operand.ram_addr, r.ram);
			if (r.bytes[23:16] == 8'hd5) chk("sfr", operand.direct_is_sfr, r.bytes[15]);
			if (r.bytes[23:16] == 8'h20) chk("bit", {operand.bit_byte, 5'h0, operand.bit_index},
				{r.bytes[15] ? {r.bytes[15:11], 3'h0} : 8'h20 + {3'h0, r.bytes[15:11]}, 5'h0,
				r.bytes[10:8]});
		end
		for (int b = 0; b < 4; b++) begin
			bank_select_field = b[1:0];
			run('{16'h0200,24'hdd0300,2'h2,1'h0,3'h2,16'h0205,8'h00}, b[0]);
			chk("bank", operand.ram_addr, {3'h0, b[1:0], 3'h5});
		end
		// Undecoded opcode runs as a single cycle
		run('{16'h0100,24'h040000,2'h1,1'h0,3'h1,16'h0000,8'h00}, 1'b0);
		chk("unknown", instr_unknown, 1'b1);
		chk("unk cycles", instr_cycles, 3'h1);
		special_function_register(1'b1, 8'h82, 8'ha5);
		chk("hit", hit_v, 1'b1);
		special_function_register(1'b1, 8'h83, 8'h3c);
		special_function_register(1'b1, 8'h81, 8'h77);
		chk("miss", hit_v, 1'b0);
		chk("dp word", data_pointer_word, 16'h3ca5);
		special_function_register(1'b0, 8'h83, 8'h00);
		chk("rd high", rd_v, 8'h3c);
		special_function_register(1'b0, 8'h82, 8'h00);
		chk("rd low", rd_v, 8'ha5);
		special_function_register(1'b0, 8'h84, 8'h00);
		chk("rd other", rd_v, 8'h00);
		// Reset in mid-instruction
		run(rows[11], 1'b0);
		bytes = 24'h02abcd;
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		@(negedge mclk);
		do_reset();
		chk("rst ready", prog_ready, 1'b1);
		chk("rst target", operand.target, 16'h0000);
		chk("rst dp", data_pointer_word, 16'h0000);
		run(rows[1], 1'b0);
		chk("a5 after rst", instr_cycles, 3'h1);
		stop_test();
	end
endmodule // operand_addressing_and_data_pointer_bench
